// file: src/sys_ctrl.v
// Purpose: clock select, sleep sequencing, reset gathering, watchdog
// Assumes: inputs synchronous to clock; analog parts sit outside
// Notes: APB slave, zero wait state after the setup cycle
`timescale 1ns/1ps
`include "sys_ctrl_map.vh"
module sys_ctrl
(
  input wire clock,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire por_low,
  input wire ext_rst_n,
  input wire brownout_detector_en,
  input wire brownout_detector_low,
  input wire scan_rst_bit,
  input wire program_debug_port_rst,
  input wire boot_vec_fuse,
  input wire [15:0] boot_vec_addr,
  input wire wdt_always_on_fuse,
  input wire ulp_1khz_tick,
  input wire watchdog_restart_instr,
  input wire [4:0] src_ready,
  input wire xosc_fail,
  input wire sleep_instr,
  input wire irq_any,
  input wire twi_match_irq,
  input wire port_async_irq,
  input wire rtc_irq,
  output reg device_rst,
  output reg io_hiz,
  output reg [15:0] reset_vector,
  output reg [2:0] clk_src_sel,
  output reg sys_clk_gate,
  output reg [4:0] pll_factor,
  output reg per4x_ce,
  output reg per2x_ce,
  output reg cpu_ce,
  output reg xosc_fail_nmi,
  output reg cal_ref_xosc32k,
  output reg cal_rc2m_en,
  output reg cal_rc32m_en,
  output reg cpu_clk_en,
  output reg nvm_clk_en,
  output reg [7:0] per_clk_en,
  output reg rtc_clk_en,
  output reg osc_run_en
);
  localparam CS_IDLE = 3'b001;
  localparam CS_GATE = 3'b010;
  localparam CS_SWAP = 3'b100;
  localparam SL_ACTIVE = 2'b01;
  localparam SL_ASLEEP = 2'b10;

  reg [2:0] cs_state;
  reg [2:0] sel_req;
  reg sel_pend;
  reg [3:0] presc_code;
  reg [10:0] presc_cnt;
  reg [1:0] fast_cnt;
  reg cfd_en;
  reg [1:0] sl_state;
  reg sleep_en;
  reg [2:0] sleep_mode;
  reg [7:0] pwr_red;
  reg [`RC_W-1:0] rst_cause;
  reg [2:0] prot_cnt;
  reg wdt_en;
  reg [3:0] wdt_per;
  reg wdt_win_en;
  reg [3:0] wdt_win_per;
  reg [14:0] wdt_cnt;
  reg wdt_fire;
  reg sw_fire;
  reg [3:0] hold_cnt;
  reg dev_rst_q;

  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire prot_open = (prot_cnt != 3'h0);
  wire cfg_rst = sys_rst | device_rst;
  wire [`RC_W-1:0] src_now;
  wire any_src = |src_now;
  wire [14:0] per_ticks = `WDT_BASE_TICKS << wdt_per;
  wire [14:0] win_ticks = `WDT_BASE_TICKS << wdt_win_per;
  wire [14:0] late_lim = wdt_win_en ? (win_ticks + per_ticks) : per_ticks;
  wire wdt_on = wdt_en | wdt_always_on_fuse;
  wire on_xosc = (clk_src_sel == `SRC_XOSC) | (clk_src_sel == `SRC_PLL);
  wire [10:0] presc_top = (11'h001 << presc_code) - 11'h001;
  reg wake;

  assign src_now[`RC_POR] = por_low;
  assign src_now[`RC_EXT] = ~ext_rst_n;
  assign src_now[`RC_BOD] = brownout_detector_en & brownout_detector_low;
  assign src_now[`RC_WDT] = wdt_fire;
  assign src_now[`RC_SCAN] = scan_rst_bit;
  assign src_now[`RC_PDI] = program_debug_port_rst;
  assign src_now[`RC_SW] = sw_fire;

  // reset gathering: held while any source stays active, then stretched
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      device_rst <= 1'b1;
      io_hiz <= 1'b1;
      hold_cnt <= `RST_HOLD_CYC;
      dev_rst_q <= 1'b1;
    end
    else
    begin
      dev_rst_q <= device_rst;
      if (any_src)
      begin
        device_rst <= 1'b1;
        io_hiz <= 1'b1;
        hold_cnt <= `RST_HOLD_CYC;
      end
      else if (hold_cnt != 4'h0)
        hold_cnt <= hold_cnt - 4'h1;
      else
      begin
        device_rst <= 1'b0;
        io_hiz <= 1'b0;
      end
    end
  end

  // reset vector is caught after release, never under reset
  always @(posedge clock)
  begin
    if (dev_rst_q & ~device_rst)
      reset_vector <= boot_vec_fuse ? boot_vec_addr : `BOOT_VEC;
    else if (sys_rst)
      reset_vector <= `BOOT_VEC;
  end

  // cause record survives device resets except POR, which overwrites it; block reset or a write of ones clears it
  always @(posedge clock)
  begin
    if (sys_rst)
      rst_cause <= {`RC_W{1'b0}};
    else if (src_now[`RC_POR])
      rst_cause <= src_now;
    else if (any_src)
      rst_cause <= rst_cause | src_now;
    else if (wr && paddr == `A_RST_STAT)
      rst_cause <= rst_cause & ~pwdata[`RC_W-1:0];
  end

  // timed write window opened by the key
  always @(posedge clock)
  begin
    if (cfg_rst)
      prot_cnt <= 3'h0;
    else if (wr && paddr == `A_PROT_KEY && pwdata[7:0] == `PROT_KEY_VAL)
      prot_cnt <= `PROT_OPEN_CYC;
    else if (wr && (paddr == `A_RST_CTRL || paddr == `A_WDT_CTRL || paddr == `A_WDT_WIN))
      prot_cnt <= 3'h0;
    else if (prot_open)
      prot_cnt <= prot_cnt - 3'h1;
  end

  // software reset request
  always @(posedge clock)
  begin
    if (cfg_rst)
      sw_fire <= 1'b0;
    else if (wr && paddr == `A_RST_CTRL && prot_open && pwdata[0])
      sw_fire <= 1'b1;
  end

  // configuration registers
  always @(posedge clock)
  begin
    if (cfg_rst)
    begin
      sel_req <= `SRC_RC2M;
      sel_pend <= 1'b0;
      pll_factor <= `PLL_RST;
      presc_code <= 4'h0;
      cfd_en <= 1'b0;
      cal_ref_xosc32k <= 1'b0;
      cal_rc2m_en <= 1'b0;
      cal_rc32m_en <= 1'b0;
      sleep_en <= 1'b0;
      sleep_mode <= `SLP_IDLE;
      pwr_red <= 8'h00;
      wdt_en <= 1'b0;
      wdt_per <= 4'h0;
      wdt_win_en <= 1'b0;
      wdt_win_per <= 4'h0;
    end
    else
    begin
      if (cs_state == CS_SWAP)
        sel_pend <= 1'b0;
      if (cfd_en & xosc_fail & on_xosc)
      begin
        sel_req <= `SRC_RC2M;
        sel_pend <= 1'b1;
      end
      else if (wr && paddr == `A_CLK_SEL && pwdata[2:0] <= `SRC_LAST)
      begin
        sel_req <= pwdata[2:0];
        sel_pend <= 1'b1;
      end
      if (wr && paddr == `A_CLK_DIV)
      begin
        if (pwdata[4:0] >= `PLL_MIN)
          pll_factor <= pwdata[4:0];
        if (pwdata[11:8] <= `PRESC_MAX)
          presc_code <= pwdata[11:8];
      end
      if (wr && paddr == `A_OSC_CTRL)
      begin
        cfd_en <= pwdata[0];
        cal_ref_xosc32k <= pwdata[1];
        cal_rc2m_en <= pwdata[2];
        cal_rc32m_en <= pwdata[3];
      end
      if (wr && paddr == `A_SLEEP_CTRL && pwdata[3:1] <= `SLP_ESTDBY)
      begin
        sleep_en <= pwdata[0];
        sleep_mode <= pwdata[3:1];
      end
      if (wr && paddr == `A_PWR_RED)
        pwr_red <= pwdata[7:0];
      if (wr && paddr == `A_WDT_CTRL && prot_open && pwdata[5:2] <= `WDT_CODE_MAX)
      begin
        wdt_en <= pwdata[1] | wdt_always_on_fuse;
        wdt_per <= pwdata[5:2];
      end
      if (wr && paddr == `A_WDT_WIN && prot_open && pwdata[5:2] <= `WDT_CODE_MAX)
      begin
        wdt_win_en <= pwdata[1];
        wdt_win_per <= pwdata[5:2];
      end
    end
  end

  // source switch: gate off, swap, gate on, only once the target runs
  always @(posedge clock)
  begin
    if (cfg_rst)
    begin
      cs_state <= CS_IDLE;
      clk_src_sel <= `SRC_RC2M;
      sys_clk_gate <= 1'b1;
    end
    else
    begin
      case (cs_state)
        CS_IDLE:
        begin
          if (sel_pend && src_ready[sel_req])
          begin
            sys_clk_gate <= 1'b0;
            cs_state <= CS_GATE;
          end
        end
        CS_GATE:
        begin
          clk_src_sel <= sel_req;
          cs_state <= CS_SWAP;
        end
        CS_SWAP:
        begin
          sys_clk_gate <= 1'b1;
          cs_state <= CS_IDLE;
        end
        default:
          cs_state <= CS_IDLE;
      endcase
    end
  end

  always @(posedge clock)
  begin
    if (cfg_rst)
      xosc_fail_nmi <= 1'b0;
    else if (cfd_en & xosc_fail & on_xosc)
      xosc_fail_nmi <= 1'b1;
    else if (wr && paddr == `A_STATUS && pwdata[8])
      xosc_fail_nmi <= 1'b0;
  end

  // prescaler gives the 4x rate; 2x and CPU rates divide it further
  always @(posedge clock)
  begin
    if (cfg_rst)
    begin
      presc_cnt <= 11'h000;
      fast_cnt <= 2'h0;
      per4x_ce <= 1'b0;
      per2x_ce <= 1'b0;
      cpu_ce <= 1'b0;
    end
    else
    begin
      per4x_ce <= 1'b0;
      per2x_ce <= 1'b0;
      cpu_ce <= 1'b0;
      if (presc_cnt >= presc_top)
      begin
        presc_cnt <= 11'h000;
        fast_cnt <= fast_cnt + 2'h1;
        per4x_ce <= 1'b1;
        per2x_ce <= fast_cnt[0];
        cpu_ce <= (fast_cnt == 2'h3);
      end
      else
        presc_cnt <= presc_cnt + 11'h001;
    end
  end

  // watchdog: counts 1 kHz ticks from the last restart
  always @(posedge clock)
  begin
    if (cfg_rst)
    begin
      wdt_cnt <= 15'h0000;
      wdt_fire <= 1'b0;
    end
    else if (!wdt_on)
      wdt_cnt <= 15'h0000;
    else if (watchdog_restart_instr)
    begin
      wdt_cnt <= 15'h0000;
      if (wdt_win_en && wdt_cnt < win_ticks)
        wdt_fire <= 1'b1;
    end
    else if (ulp_1khz_tick)
    begin
      if (wdt_cnt + 15'h0001 >= late_lim)
        wdt_fire <= 1'b1;
      else
        wdt_cnt <= wdt_cnt + 15'h0001;
    end
  end

  // wake sources per sleep mode
  always @*
  begin
    wake = 1'b0;
    case (sleep_mode)
      `SLP_IDLE: wake = irq_any;
      `SLP_PDOWN: wake = twi_match_irq | port_async_irq;
      `SLP_STDBY: wake = twi_match_irq | port_async_irq;
      `SLP_PSAVE: wake = twi_match_irq | port_async_irq | rtc_irq;
      `SLP_ESTDBY: wake = twi_match_irq | port_async_irq | rtc_irq;
      default: wake = irq_any;
    endcase
  end

  always @(posedge clock)
  begin
    if (cfg_rst)
      sl_state <= SL_ACTIVE;
    else
    begin
      case (sl_state)
        SL_ACTIVE:
          if (sleep_instr & sleep_en)
            sl_state <= SL_ASLEEP;
        SL_ASLEEP:
          if (wake)
            sl_state <= SL_ACTIVE;
        default:
          sl_state <= SL_ACTIVE;
      endcase
    end
  end

  // clock gating; a gated peripheral simply sees no clock and holds state
  always @(posedge clock)
  begin
    if (cfg_rst)
    begin
      cpu_clk_en <= 1'b1;
      nvm_clk_en <= 1'b1;
      per_clk_en <= 8'hFF;
      rtc_clk_en <= 1'b1;
      osc_run_en <= 1'b1;
    end
    else if (sl_state == SL_ACTIVE)
    begin
      cpu_clk_en <= 1'b1;
      nvm_clk_en <= 1'b1;
      per_clk_en <= ~pwr_red;
      rtc_clk_en <= 1'b1;
      osc_run_en <= 1'b1;
    end
    else
    begin
      cpu_clk_en <= 1'b0;
      nvm_clk_en <= 1'b0;
      per_clk_en <= (sleep_mode == `SLP_IDLE) ? ~pwr_red : 8'h00;
      rtc_clk_en <= (sleep_mode == `SLP_IDLE) | (sleep_mode == `SLP_PSAVE)
        | (sleep_mode == `SLP_ESTDBY);
      osc_run_en <= (sleep_mode == `SLP_IDLE) | (sleep_mode == `SLP_STDBY)
        | (sleep_mode == `SLP_ESTDBY);
    end
  end

  // APB: pready rises for the access cycle right after setup
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel & ~penable)
      begin
        case (paddr)
          `A_CLK_SEL: prdata <= {29'h0, sel_req};
          `A_CLK_DIV: prdata <= {20'h0, presc_code, 3'h0, pll_factor};
          `A_OSC_CTRL: prdata <= {28'h0, cal_rc32m_en, cal_rc2m_en, cal_ref_xosc32k, cfd_en};
          `A_SLEEP_CTRL: prdata <= {28'h0, sleep_mode, sleep_en};
          `A_PWR_RED: prdata <= {24'h0, pwr_red};
          `A_RST_STAT: prdata <= {25'h0, rst_cause};
          `A_RST_CTRL: prdata <= 32'h00000000;
          `A_WDT_CTRL: prdata <= {26'h0, wdt_per, wdt_on, 1'b0};
          `A_WDT_WIN: prdata <= {26'h0, wdt_win_per, wdt_win_en, 1'b0};
          `A_PROT_KEY: prdata <= {31'h0, prot_open};
          `A_STATUS: prdata <= {23'h0, xosc_fail_nmi, sl_state[1], sel_pend,
            sys_clk_gate, 2'h0, clk_src_sel};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule

// file: src/sys_ctrl_map.vh
// Purpose: register map and constants of the system control block
// Assumes: 32-bit APB, one aligned word per register
// Notes: definitions only
`ifndef SYS_CTRL_MAP_VH
`define SYS_CTRL_MAP_VH
`define A_CLK_SEL 8'h00
`define A_CLK_DIV 8'h04
`define A_OSC_CTRL 8'h08
`define A_SLEEP_CTRL 8'h0C
`define A_PWR_RED 8'h10
`define A_RST_STAT 8'h14
`define A_RST_CTRL 8'h18
`define A_WDT_CTRL 8'h1C
`define A_WDT_WIN 8'h20
`define A_PROT_KEY 8'h24
`define A_STATUS 8'h28
// clock source codes; the ultra-low-power oscillator has none on purpose
`define SRC_RC2M 3'h0
`define SRC_RC32M 3'h1
`define SRC_RC32K 3'h2
`define SRC_XOSC 3'h3
`define SRC_PLL 3'h4
`define SRC_LAST 3'h4
`define PLL_MIN 5'h02
`define PLL_MAX 5'h1F
`define PLL_RST 5'h02
`define PRESC_MAX 4'hB
// sleep mode codes
`define SLP_IDLE 3'h0
`define SLP_PDOWN 3'h1
`define SLP_PSAVE 3'h2
`define SLP_STDBY 3'h3
`define SLP_ESTDBY 3'h4
// reset cause bit positions
`define RC_POR 0
`define RC_EXT 1
`define RC_BOD 2
`define RC_WDT 3
`define RC_SCAN 4
`define RC_PDI 5
`define RC_SW 6
`define RC_W 7
// timed write sequence
`define PROT_KEY_VAL 8'hD8
`define PROT_OPEN_CYC 3'h4
// device reset stretch after all sources release
`define RST_HOLD_CYC 4'h8
// watchdog: code n gives 8 << n ticks of 1 kHz, 8 ms to 8 s
`define WDT_BASE_TICKS 15'h0008
`define WDT_CODE_MAX 4'hA
`define NUM_PER 8
`define BOOT_VEC 16'h0000
`endif

// file: testbench/cpu_side_model.sv
// Purpose: CPU, debug port and reset pin as seen by the block
// Assumes: strobe is called from the bench's main process
// Notes: requests change only right after a rising edge
`timescale 1ns/1ps
module cpu_side_model
(
  input wire clock,
  output logic ext_rst_n,
  output logic program_debug_port_rst,
  output logic watchdog_restart_instr,
  output logic sleep_instr
);
  // bit order: sleep, restart, debug reset, pin low
  logic [3:0] act = 4'h0;
  assign sleep_instr = act[3];
  assign watchdog_restart_instr = act[2];
  assign program_debug_port_rst = act[1];
  assign ext_rst_n = !act[0];
  task automatic strobe(input logic [3:0] mask, input int cycles);
    @(posedge clock);
    act <= mask;
    repeat (cycles) @(posedge clock);
    act <= 4'h0;
  endtask
endmodule

// file: testbench/sys_ctrl_chk.sv
// Purpose: port-level checks of the system control block
// Assumes: one clock, sys_rst synchronous and active high
// Notes: bound to sys_ctrl from the bench top file
`timescale 1ns/1ps
module sys_ctrl_chk
(
  input wire clock,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire por_low,
  input wire ext_rst_n,
  input wire brownout_detector_en,
  input wire brownout_detector_low,
  input wire scan_rst_bit,
  input wire program_debug_port_rst,
  input wire boot_vec_fuse,
  input wire [15:0] boot_vec_addr,
  input wire device_rst,
  input wire io_hiz,
  input wire [15:0] reset_vector,
  input wire [2:0] clk_src_sel,
  input wire sys_clk_gate,
  input wire [4:0] pll_factor
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_ext_pin_rst: assert property (!ext_rst_n |=> device_rst && io_hiz)
    else $error("reset pin ignored");
  a_supply_rst: assert property (
    por_low || brownout_detector_en && brownout_detector_low |=> device_rst)
    else $error("supply reset ignored");
  a_debug_rst: assert property (
    scan_rst_bit || program_debug_port_rst |=> device_rst)
    else $error("scan or debug reset ignored");
  a_src_after_rst: assert property (device_rst |=> clk_src_sel == 3'h0)
    else $error("clock source not back to rc2m");
  a_src_range: assert property (clk_src_sel <= 3'h4 && pll_factor >= 5'h02)
    else $error("clock source or multiplier out of range");
  // switches to the rc2m source are exempt here, though a fallback still passes through the gated swap
  a_switch_gated: assert property (
    $changed(clk_src_sel) && !device_rst && clk_src_sel != 3'h0
    |-> !sys_clk_gate && $past(sys_clk_gate) == 1'b0) else $error("switch not gated");
  a_vec_capture: assert property ($fell(device_rst)
    |=> reset_vector == (boot_vec_fuse ? boot_vec_addr : 16'h0000)) else $error("bad vector");
  a_hiz_with_rst: assert property ($rose(device_rst) |-> io_hiz)
    else $error("pins not tri-stated");
  a_ready_due: assert property (psel && !penable |=> pready)
    else $error("pready late");
  a_ready_only: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("pready outside access");
endmodule

// file: testbench/system_clock_sleep_reset_watchdog_test.sv
// Purpose: self-checking bench of the system control block
// Assumes: APB slave answers in the first access cycle
// Notes: 1 kHz tick sped up to one pulse per four clocks
`timescale 1ns/1ps
`include "sys_ctrl_map.vh"
module system_clock_sleep_reset_watchdog_test;
  logic clock, sys_rst, psel, penable, pwrite, pready, pslverr, por_low, xosc_fail, err, tick_en;
  logic brownout_detector_en, brownout_detector_low, scan_rst_bit, boot_vec_fuse;
  logic wdt_always_on_fuse, irq_any, twi_match_irq, port_async_irq, rtc_irq;
  logic ext_rst_n, program_debug_port_rst, watchdog_restart_instr, sleep_instr;
  logic device_rst, io_hiz, sys_clk_gate, per4x_ce, per2x_ce, cpu_ce, xosc_fail_nmi;
  logic cal_ref_xosc32k, cal_rc2m_en, cal_rc32m_en, cpu_clk_en, nvm_clk_en, rtc_clk_en;
  logic osc_run_en;
  logic ulp_1khz_tick = 1'b0;
  logic [2:0] clk_src_sel;
  logic [4:0] src_ready, pll_factor;
  logic [7:0] paddr, per_clk_en;
  logic [15:0] boot_vec_addr, reset_vector;
  logic [31:0] pwdata, prdata, rd;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int n4, n2, n1;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] r; logic e;} row_t;
  // illegal field values must leave the old contents in place
  row_t rows [6] = '{'{`A_CLK_DIV, 32'hB1F, 32'hB1F, 0}, '{`A_CLK_DIV, 32'hC01, 32'hB1F, 0},
    '{`A_OSC_CTRL, 32'hE, 32'hE, 0}, '{`A_PWR_RED, 32'hA5, 32'hA5, 0},
    '{`A_CLK_SEL, 32'h5, 32'h0, 0}, '{8'h2C, 32'h1, 32'h0, 1}};
  logic [31:0] cause [5] = '{32'h01, 32'h04, 32'h10, 32'h02, 32'h20};
  logic [3:0] gate_exp [5] = '{4'h3, 4'h0, 4'h2, 4'h1, 4'h3};
  logic [3:0] wake [5] = '{4'h8, 4'h4, 4'h1, 4'h2, 4'h1};

  sys_ctrl sys_ctrl_inst (.*);
  cpu_side_model cpu_side_model_inst (.*);

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    ulp_1khz_tick <= tick_en && (cycles % 4 == 0);
    if (cycles == 20000)
    begin
      $display("ERROR timeout expected finish seen hang");
      n_errors++;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic key();
    apb(1'b1, `A_PROT_KEY, {24'h0, `PROT_KEY_VAL});
  endtask

  task automatic wait_rst(input logic v, input int lim);
    int n;
    n = 0;
    while (device_rst !== v && n < lim)
    begin
      @(posedge clock);
      n++;
    end
    chk("device_rst", v, device_rst);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, tick_en, xosc_fail, wdt_always_on_fuse} = '0;
    {por_low, brownout_detector_low, scan_rst_bit} = '0;
    {irq_any, twi_match_irq, port_async_irq, rtc_irq} = '0;
    {brownout_detector_en, boot_vec_fuse, boot_vec_addr, src_ready} = {2'b11, 16'h1234, 5'h17};
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk("reset state", {1'b1, 3'h0, 5'h02}, {device_rst, clk_src_sel, pll_factor});
    wait_rst(1'b0, 30);
    $display("test reset done");
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk("pslverr", rows[i].e, err);
      if (!rows[i].e)
        chk("read back", rows[i].r, rd);
    end
    chk("pll_factor", 5'h1F, pll_factor);
    chk("cal enables", 3'h7, {cal_ref_xosc32k, cal_rc2m_en, cal_rc32m_en});
    chk("per_clk_en", 8'h5A, per_clk_en);
    apb(1'b1, `A_PWR_RED, 32'h0);
    $display("test register rows done");
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b1, `A_RST_STAT, 32'h7F);
      if (k < 3)
        {scan_rst_bit, brownout_detector_low, por_low} <= 3'b1 << k;
      else
        cpu_side_model_inst.strobe(k == 3 ? 4'h1 : 4'h2, 3);
      repeat (3) @(posedge clock);
      {scan_rst_bit, brownout_detector_low, por_low} <= 3'b0;
      wait_rst(1'b0, 30);
      apb(1'b0, `A_RST_STAT, 32'h0);
      chk("reset cause", cause[k], rd);
    end
    chk("reset_vector", 16'h1234, reset_vector);
    {brownout_detector_en, brownout_detector_low} <= 2'b01;
    repeat (4) @(posedge clock);
    chk("disabled brown-out", 1'b0, device_rst);
    brownout_detector_low <= 1'b0;
    $display("test reset sources done");
    apb(1'b1, `A_CLK_SEL, 32'h1);
    repeat (4) @(posedge clock);
    chk("switch to rc32m", 3'h1, clk_src_sel);
    apb(1'b1, `A_CLK_SEL, {29'h0, `SRC_XOSC});
    repeat (4) @(posedge clock);
    chk("switch waits", 3'h1, clk_src_sel);
    apb(1'b1, `A_OSC_CTRL, 32'h1);
    src_ready <= 5'h1F;
    repeat (4) @(posedge clock);
    chk("switch to xosc", 3'h3, clk_src_sel);
    xosc_fail <= 1'b1;
    repeat (4) @(posedge clock);
    chk("fallback", 4'h8, {xosc_fail_nmi, clk_src_sel});
    xosc_fail <= 1'b0;
    apb(1'b1, `A_STATUS, 32'h100);
    repeat (2) @(posedge clock);
    chk("nmi cleared", 1'b0, xosc_fail_nmi);
    apb(1'b1, `A_CLK_SEL, 32'h1);
    $display("test clock switch done");
    apb(1'b1, `A_RST_STAT, 32'h7F);
    apb(1'b1, `A_RST_CTRL, 32'h1);
    repeat (4) @(posedge clock);
    chk("unkeyed reset", 1'b0, device_rst);
    boot_vec_fuse <= 1'b0;
    key();
    apb(1'b1, `A_RST_CTRL, 32'h1);
    wait_rst(1'b1, 4);
    wait_rst(1'b0, 30);
    apb(1'b0, `A_RST_STAT, 32'h0);
    chk("sw cause", 32'h40, rd);
    chk("source after reset", 3'h0, clk_src_sel);
    chk("reset_vector", 16'h0000, reset_vector);
    $display("test software reset done");
    tick_en <= 1'b1;
    apb(1'b1, `A_WDT_CTRL, 32'h2);
    repeat (48) @(posedge clock);
    chk("unkeyed watchdog", 1'b0, device_rst);
    apb(1'b1, `A_RST_STAT, 32'h7F);
    key();
    apb(1'b1, `A_WDT_CTRL, 32'h2);
    repeat (6)
    begin
      repeat (20) @(posedge clock);
      cpu_side_model_inst.strobe(4'h4, 1);
    end
    repeat (22) @(posedge clock);
    chk("watchdog early", 1'b0, device_rst);
    wait_rst(1'b1, 16);
    wait_rst(1'b0, 30);
    apb(1'b0, `A_RST_STAT, 32'h0);
    chk("watchdog cause", 32'h08, rd);
    key();
    apb(1'b1, `A_WDT_WIN, 32'h2);
    key();
    apb(1'b1, `A_WDT_CTRL, 32'h2);
    cpu_side_model_inst.strobe(4'h4, 1);
    wait_rst(1'b1, 8);
    wait_rst(1'b0, 30);
    $display("test watchdog done");
    for (int m = 0; m < 5; m++)
    begin
      apb(1'b1, `A_SLEEP_CTRL, {28'h0, m[2:0], 1'b1});
      cpu_side_model_inst.strobe(4'h8, 1);
      repeat (3) @(posedge clock);
      rd = {cpu_clk_en, nvm_clk_en, rtc_clk_en, osc_run_en, per_clk_en};
      chk("sleep gating", gate_exp[m], rd[11:8]);
      chk("sleep per_clk_en", m == 0 ? 8'hFF : 8'h00, rd[7:0]);
      if (m != 0)
        {irq_any, twi_match_irq, port_async_irq, rtc_irq} <= 4'h8;
      repeat (3) @(posedge clock);
      chk("no wake", 1'b0, cpu_clk_en);
      {irq_any, twi_match_irq, port_async_irq, rtc_irq} <= wake[m];
      repeat (3) @(posedge clock);
      chk("wake", 1'b1, cpu_clk_en);
      {irq_any, twi_match_irq, port_async_irq, rtc_irq} <= 4'h0;
    end
    $display("test sleep modes done");
    wdt_always_on_fuse <= 1'b1;
    key();
    apb(1'b1, `A_WDT_CTRL, 32'h0);
    wait_rst(1'b1, 48);
    wdt_always_on_fuse <= 1'b0;
    wait_rst(1'b0, 30);
    $display("test always-on watchdog done");
    apb(1'b1, `A_CLK_DIV, 32'h102);
    repeat (4) @(posedge clock);
    n4 = 0;
    n2 = 0;
    n1 = 0;
    repeat (64)
    begin
      @(posedge clock);
      n4 += per4x_ce;
      n2 += per2x_ce;
      n1 += cpu_ce;
    end
    chk("fast enables", {8'h20, 8'h10, 8'h08}, {n4[7:0], n2[7:0], n1[7:0]});
    $display("test clock enables done");
    conclude();
  end
endmodule

bind sys_ctrl sys_ctrl_chk sys_ctrl_chk_inst (.*);
